// [verilog/dsp_memory_and_bus_control.sv]
// On-chip RAM blocks, memory-mapped registers and external bus control.
// Assumes a core that issues one request at a time and a synchronous
// external bus; tristate wires are resolved outside from the enables.
`timescale 1ns/1ns
`include "dsp_mem_consts.svh"

module dsp_memory_and_bus_control (
  input  wire logic                clk,
  input  wire logic                srst,
  input  wire logic                req_valid,
  output logic                     req_ready,
  input  wire dsp_mem_pkg::space_e req_space,
  input  wire logic [15:0]         req_addr,
  input  wire logic                req_write,
  input  wire logic [15:0]         req_wdata,
  output logic                     rsp_valid,
  output logic [15:0]              rsp_rdata,
  input  wire logic                map_block_to_data_space,
  input  wire logic                map_block_to_program_space,
  output logic                     block_in_program,
  input  wire logic                repeat_active,
  input  wire logic                irq_pending,
  output logic                     irq_allow,
  input  wire logic [15:0]         serial_rx_in,
  output logic [15:0]              serial_tx_reg,
  output logic [15:0]              timer_count_reg,
  output logic [15:0]              timer_period_reg,
  output logic [15:0]              irq_mask_reg,
  output logic [7:0]               global_region_size_reg,
  output logic [15:0]              ext_addr,
  output logic                     ext_addr_oe,
  output logic [15:0]              ext_data_out,
  output logic                     ext_data_oe,
  input  wire logic [15:0]         ext_data_in,
  output logic                     ext_strobe_n,
  output logic                     ext_read_n_write,
  output logic                     ext_prog_sel_n,
  output logic                     ext_data_sel_n,
  output logic                     ext_io_sel_n,
  output logic                     ext_ctrl_oe,
  input  wire logic                ext_ready,
  output logic                     bus_request_out,
  input  wire logic                hold_req_n,
  output logic                     hold_ack_out
);
  import dsp_mem_pkg::*;
  // On-chip RAM blocks
  logic [15:0] sw_mem   [`DSP_SW_WORDS];
  logic [15:0] fix1_mem [`DSP_FIX1_WORDS];
  logic [15:0] fix2_mem [`DSP_FIX2_WORDS];
  bus_state_e  state_reg, state_next;
  space_e      space_reg, space_next;
  logic [15:0] addr_reg, addr_next, wdata_reg, wdata_next;
  logic        we_reg, we_next, br_reg, br_next;
  logic        cfg_reg, cfg_next, rsp_reg, rsp_next;
  logic [15:0] rdata_reg, rdata_next;
  logic [15:0] tx_reg, tx_next, tim_reg, tim_next;
  logic [15:0] prd_reg, prd_next, imr_reg, imr_next;
  logic [7:0]  global_region_size_reg_reg, global_region_size_reg_next;
  logic hit_mmr, hit_fix1, hit_fix2, hit_sw, is_int, is_global;
  logic take, take_int, take_ext;
  logic [15:0] int_rdata;
  logic [8:0]  page_sum;
  // Address decode for the current request
  always_comb begin
    hit_mmr  = 1'b0;
    hit_fix1 = 1'b0;
    hit_fix2 = 1'b0;
    hit_sw   = 1'b0;
    is_int   = 1'b0;
    if (req_space == SP_DATA) begin
      hit_mmr  = req_addr <= `DSP_MMR_LAST;
      hit_fix2 = req_addr[15:5] == `DSP_FIX2_PAGE;
      hit_fix1 = req_addr[15:8] == `DSP_FIX1_PAGE;
      hit_sw   = !cfg_reg && req_addr[15:8] == `DSP_SW_DATA_PAGE;
      // Low data area up to the fixed block is on-chip, unused reads zero
      is_int   = req_addr[15:10] == 6'h00;
    end else if (req_space == SP_PROG) begin
      hit_sw = cfg_reg && req_addr[15:8] == `DSP_SW_PROG_PAGE;
      is_int = hit_sw;
    end
    page_sum  = {1'b0, req_addr[15:8]} + {1'b0, global_region_size_reg_reg};
    // Global region is the top global_region_size_reg pages of external data space
    is_global = req_space == SP_DATA && !is_int &&
                page_sum > `DSP_TOP_PAGE;
  end
  // Internal read mux
  always_comb begin
    int_rdata = `DSP_WORD_RST;
    if (hit_mmr) begin
      case (req_addr[2:0])
        `DSP_MMR_RX:   int_rdata = serial_rx_in;
        `DSP_MMR_TX:   int_rdata = tx_reg;
        `DSP_MMR_TIM:  int_rdata = tim_reg;
        `DSP_MMR_PRD:  int_rdata = prd_reg;
        `DSP_MMR_IMR:  int_rdata = imr_reg;
        `DSP_MMR_GLOBAL_REGION_SIZE_REG: int_rdata = {8'h00, global_region_size_reg_reg};
        default:       int_rdata = `DSP_WORD_RST;
      endcase
    end else if (hit_fix1) begin
      int_rdata = fix1_mem[req_addr[7:0]];
    end else if (hit_fix2) begin
      int_rdata = fix2_mem[req_addr[4:0]];
    end else if (hit_sw) begin
      int_rdata = sw_mem[req_addr[7:0]];
    end
  end
  // Request acceptance; on-chip path stays open during hold
  always_comb begin
    req_ready = is_int ? (state_reg != ST_EXT)
                       : (state_reg == ST_IDLE && hold_req_n);
    take      = req_valid && req_ready;
    take_int  = take && is_int;
    take_ext  = take && !is_int;
  end
  // Next state of bus controller and registers
  always_comb begin
    state_next = state_reg;
    space_next = space_reg;
    addr_next  = addr_reg;
    wdata_next = wdata_reg;
    we_next    = we_reg;
    br_next    = br_reg;
    rsp_next   = 1'b0;
    rdata_next = rdata_reg;
    cfg_next   = cfg_reg;
    tx_next    = tx_reg;
    tim_next   = tim_reg;
    prd_next   = prd_reg;
    imr_next   = imr_reg;
    global_region_size_reg_next  = global_region_size_reg_reg;
    if (map_block_to_data_space) begin
      cfg_next = 1'b0;
    end else if (map_block_to_program_space) begin
      cfg_next = 1'b1;
    end
    if (take_int) begin
      rsp_next   = 1'b1;
      rdata_next = int_rdata;
      if (req_write && hit_mmr) begin
        case (req_addr[2:0])
          `DSP_MMR_TX:   tx_next   = req_wdata;
          `DSP_MMR_TIM:  tim_next  = req_wdata;
          `DSP_MMR_PRD:  prd_next  = req_wdata;
          `DSP_MMR_IMR:  imr_next  = req_wdata;
          `DSP_MMR_GLOBAL_REGION_SIZE_REG: global_region_size_reg_next = req_wdata[7:0];
          default:       tx_next   = tx_reg;
        endcase
      end
    end
    case (state_reg)
      ST_IDLE: begin
        if (!hold_req_n) begin
          state_next = ST_HOLD_ENTER;
        end else if (take_ext) begin
          state_next = ST_EXT;
          space_next = req_space;
          addr_next  = req_addr;
          wdata_next = req_wdata;
          we_next    = req_write;
          br_next    = is_global;
        end
      end
      ST_EXT: begin
        if (ext_ready) begin
          state_next = ST_IDLE;
          rsp_next   = 1'b1;
          rdata_next = we_reg ? rdata_reg : ext_data_in;
          br_next    = 1'b0;
        end
      end
      ST_HOLD_ENTER: state_next = hold_req_n ? ST_IDLE : ST_HOLD;
      ST_HOLD:       state_next = hold_req_n ? ST_IDLE : ST_HOLD;
      default:       state_next = ST_IDLE;
    endcase
  end
  // Register update
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      space_reg <= SP_PROG;
      addr_reg  <= `DSP_WORD_RST;
      wdata_reg <= `DSP_WORD_RST;
      we_reg    <= 1'b0;
      br_reg    <= 1'b0;
      rsp_reg   <= 1'b0;
      rdata_reg <= `DSP_WORD_RST;
      cfg_reg   <= `DSP_CFG_RST;
      tx_reg    <= `DSP_WORD_RST;
      tim_reg   <= `DSP_WORD_RST;
      prd_reg   <= `DSP_WORD_RST;
      imr_reg   <= `DSP_WORD_RST;
      global_region_size_reg_reg  <= `DSP_GLOBAL_REGION_SIZE_REG_RST;
    end else begin
      state_reg <= state_next;
      space_reg <= space_next;
      addr_reg  <= addr_next;
      wdata_reg <= wdata_next;
      we_reg    <= we_next;
      br_reg    <= br_next;
      rsp_reg   <= rsp_next;
      rdata_reg <= rdata_next;
      cfg_reg   <= cfg_next;
      tx_reg    <= tx_next;
      tim_reg   <= tim_next;
      prd_reg   <= prd_next;
      imr_reg   <= imr_next;
      global_region_size_reg_reg  <= global_region_size_reg_next;
    end
  end
  // RAM writes; program-space writes load code into the switchable block
  always_ff @(posedge clk) begin
    if (take_int && req_write) begin
      if (hit_fix1) begin
        fix1_mem[req_addr[7:0]] <= req_wdata;
      end else if (hit_fix2) begin
        fix2_mem[req_addr[4:0]] <= req_wdata;
      end else if (hit_sw) begin
        sw_mem[req_addr[7:0]] <= req_wdata;
      end
    end
  end
  // Outputs; bus released in both hold states
  always_comb begin
    ext_addr_oe      = state_reg == ST_IDLE || state_reg == ST_EXT;
    ext_ctrl_oe      = ext_addr_oe;
    ext_data_oe      = state_reg == ST_EXT && we_reg;
    ext_strobe_n     = state_reg != ST_EXT;
    ext_read_n_write = !(state_reg == ST_EXT && we_reg);
    ext_prog_sel_n   = !(state_reg == ST_EXT && space_reg == SP_PROG);
    ext_data_sel_n   = !(state_reg == ST_EXT && space_reg == SP_DATA);
    ext_io_sel_n     = !(state_reg == ST_EXT && space_reg == SP_IO);
    hold_ack_out     = state_reg == ST_HOLD;
    irq_allow        = irq_pending && state_reg != ST_EXT &&
                       !repeat_active;
  end
  assign ext_addr               = addr_reg;
  assign ext_data_out           = wdata_reg;
  assign bus_request_out        = br_reg;
  assign rsp_valid              = rsp_reg;
  assign rsp_rdata              = rdata_reg;
  assign block_in_program       = cfg_reg;
  assign serial_tx_reg          = tx_reg;
  assign timer_count_reg        = tim_reg;
  assign timer_period_reg       = prd_reg;
  assign irq_mask_reg           = imr_reg;
  assign global_region_size_reg = global_region_size_reg_reg;
  // Checks on bus handover, waits and configuration
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_hold_bus_float: assert property (
    hold_ack_out |-> !ext_addr_oe && !ext_data_oe) else $error("bus driven");
  a_hold_ack_entry: assert property (state_reg == ST_IDLE &&
    !hold_req_n ##1 !hold_req_n |=> hold_ack_out) else $error("no ack");
  a_hold_release: assert property (hold_ack_out && hold_req_n
    |=> !hold_ack_out && ext_addr_oe) else $error("release wrong");
  a_ready_stall: assert property (state_reg == ST_EXT && !ext_ready
    |=> state_reg == ST_EXT && !rsp_valid) else $error("no stall");
  a_no_wait_int: assert property (take_int |=> rsp_valid)
    else $error("on-chip access waited");
  a_br_global_only: assert property (bus_request_out |->
    state_reg == ST_EXT && space_reg == SP_DATA) else $error("stray br");
  a_br_clear: assert property (state_reg == ST_EXT && ext_ready
    |=> !bus_request_out && rsp_valid) else $error("br not dropped");
  a_irq_deferred: assert property (state_reg == ST_EXT ||
    repeat_active |-> !irq_allow) else $error("irq not deferred");
  a_cfg_program: assert property (map_block_to_program_space &&
    !map_block_to_data_space |=> block_in_program) else $error("not moved");
endmodule : dsp_memory_and_bus_control

// [pkg/dsp_mem_consts.svh]
// Named constants of the memory and bus control block.
// Included by its bare name; holds definitions only.
`ifndef DSP_MEM_CONSTS_SVH
`define DSP_MEM_CONSTS_SVH

// Data and program space decode (upper address bits; MMR limit is a full address)
`define DSP_MMR_LAST     16'h0005
`define DSP_FIX2_PAGE    11'h003
`define DSP_SW_DATA_PAGE 8'h02
`define DSP_FIX1_PAGE    8'h03
`define DSP_SW_PROG_PAGE 8'hff

// Memory-mapped register indices (address bits 2:0)
`define DSP_MMR_RX    3'h0
`define DSP_MMR_TX    3'h1
`define DSP_MMR_TIM   3'h2
`define DSP_MMR_PRD   3'h3
`define DSP_MMR_IMR   3'h4
`define DSP_MMR_GLOBAL_REGION_SIZE_REG  3'h5

// Block sizes
`define DSP_SW_WORDS  256
`define DSP_FIX1_WORDS 256
`define DSP_FIX2_WORDS 32

// Reset values, then the top data page for the global decode
`define DSP_WORD_RST  16'h0000
`define DSP_GLOBAL_REGION_SIZE_REG_RST  8'h00
`define DSP_CFG_RST   1'b0
`define DSP_TOP_PAGE  9'h0ff

`endif

// [pkg/dsp_mem_pkg.sv]
// Types of the memory and bus control block.
// Shared by the design and the bench.
package dsp_mem_pkg;

  // Bus controller states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE       = 4'h1,
    ST_EXT        = 4'h2,
    ST_HOLD_ENTER = 4'h4,
    ST_HOLD       = 4'h8
  } bus_state_e;

  // Address spaces
  typedef enum logic [1:0] {
    SP_PROG = 2'h0,
    SP_DATA = 2'h1,
    SP_IO   = 2'h2
  } space_e;

endpackage : dsp_mem_pkg

// [tb/ext_mem_model.sv]
// External memory and I/O model for the bus control block.
// Assumes one access at a time; ready follows a wait count.
`timescale 1ns/1ns
module ext_mem_model (
  input  wire logic        clk,
  input  wire logic [15:0] ext_addr,
  input  wire logic [15:0] ext_data_out,
  input  wire logic        ext_strobe_n,
  input  wire logic        ext_read_n_write,
  input  wire logic [3:0]  waits,
  output logic [15:0]      ext_data_in,
  output logic             ext_ready
);
  logic [15:0] mem [256];
  logic [3:0]  cnt_reg;
  logic [15:0] last_reg;
  // Completion only after the chosen wait cycles
  assign ext_ready = !ext_strobe_n && cnt_reg >= waits;
  // Undriven bus shows the inverse of the last value
  assign ext_data_in = ext_ready ? mem[ext_addr[7:0]] : ~last_reg;
  // Wait count, stored writes, last bus value
  always_ff @(posedge clk) begin
    cnt_reg <= ext_strobe_n ? 4'h0 : cnt_reg + 4'h1;
    last_reg <= ext_data_in;
    if (ext_ready && !ext_read_n_write)
      mem[ext_addr[7:0]] <= ext_data_out;
  end
endmodule : ext_mem_model

// [tb/dsp_memory_and_bus_control_tb.sv]
// Self-checking bench for the memory and bus control block.
// Assumes the external memory model on the far side, one clock.
`timescale 1ns/1ns
module dsp_memory_and_bus_control_tb;
  import dsp_mem_pkg::*;
  logic        clk, srst, req_valid, req_ready, req_write, rsp_valid;
  logic        map_block_to_data_space, map_block_to_program_space;
  logic        block_in_program, repeat_active, irq_pending, irq_allow;
  logic        ext_addr_oe, ext_data_oe, ext_strobe_n, ext_read_n_write;
  logic        ext_prog_sel_n, ext_data_sel_n, ext_io_sel_n, ext_ctrl_oe;
  logic        ext_ready, bus_request_out, hold_req_n, hold_ack_out;
  logic        br_seen, irq_seen;
  logic [15:0] req_addr, req_wdata, rsp_rdata, ext_addr, ext_data_out;
  logic [15:0] ext_data_in, serial_rx_in, lat;
  logic [7:0]  global_region_size_reg;
  logic [3:0]  waits;
  space_e      req_space;
  int          errors, tests_run, cycles;

  dsp_memory_and_bus_control dut (.*, .serial_tx_reg(),
    .timer_count_reg(), .timer_period_reg(), .irq_mask_reg());
  ext_mem_model mem (.*);

  // Clock, 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      conclude();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, got);
    tests_run++;
    if (got !== exp)
      $display("Error %s expected %h seen %h", what, exp, got);
    if (got !== exp)
      errors++;
  endtask : chk

  // One core request; lat counts cycles from take to answer
  task automatic access(input space_e sp, input logic [15:0] a,
                        input logic w, input logic [15:0] d);
    @(posedge clk);
    req_valid <= 1'b1;
    req_space <= sp;
    req_addr  <= a;
    req_write <= w;
    req_wdata <= d;
    @(negedge clk);
    while (req_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    req_valid <= 1'b0;
    lat = 16'h0;
    br_seen = 1'b0;
    irq_seen = 1'b0;
    do begin
      @(negedge clk);
      lat++;
      br_seen |= bus_request_out;
      if (rsp_valid !== 1'b1) irq_seen |= irq_allow;
    end while (rsp_valid !== 1'b1);
  endtask : access

  task automatic pulse_map(input logic to_data, to_prog);
    @(posedge clk);
    map_block_to_data_space <= to_data;
    map_block_to_program_space <= to_prog;
    @(posedge clk);
    map_block_to_data_space <= 1'b0;
    map_block_to_program_space <= 1'b0;
    @(negedge clk);
  endtask : pulse_map

  // Block contents, remap and the data-space gap
  task automatic ram_test();
    access(SP_DATA, 16'h0300, 1'b1, 16'h1111);
    chk("int lat", 16'h1, lat);
    access(SP_DATA, 16'h0060, 1'b1, 16'h2222);
    access(SP_DATA, 16'h0200, 1'b1, 16'h3333);
    access(SP_DATA, 16'h0060, 1'b0, 16'h0);
    chk("fix2", 16'h2222, rsp_rdata);
    pulse_map(1'b0, 1'b1);
    chk("prog map", 16'h1, block_in_program);
    access(SP_DATA, 16'h0200, 1'b0, 16'h0);
    chk("gap", 16'h0, rsp_rdata);
    access(SP_PROG, 16'hff00, 1'b0, 16'h0);
    chk("prog rd", 16'h3333, rsp_rdata);
    access(SP_PROG, 16'hff01, 1'b1, 16'h4444);
    access(SP_DATA, 16'h0300, 1'b0, 16'h0);
    chk("fix1", 16'h1111, rsp_rdata);
    access(SP_PROG, 16'h1000, 1'b0, 16'h0);
    chk("ext prog", 16'h2, lat);
    pulse_map(1'b1, 1'b1);
    chk("data map", 16'h0, block_in_program);
    access(SP_DATA, 16'h0201, 1'b0, 16'h0);
    chk("kept", 16'h4444, rsp_rdata);
  endtask : ram_test

  // Mapped registers and interrupt gating
  task automatic reg_test();
    access(SP_DATA, 16'h0000, 1'b0, 16'h0);
    chk("rx", 16'h5a3c, rsp_rdata);
    access(SP_DATA, 16'h0001, 1'b1, 16'habcd);
    access(SP_DATA, 16'h0001, 1'b0, 16'h0);
    chk("tx", 16'habcd, rsp_rdata);
    access(SP_DATA, 16'h0005, 1'b1, 16'hff01);
    access(SP_DATA, 16'h0005, 1'b0, 16'h0);
    chk("global_region_size_reg", 16'h0001, rsp_rdata);
    chk("irq ok", 16'h1, irq_allow);
    @(posedge clk);
    repeat_active <= 1'b1;
    @(negedge clk);
    chk("irq rpt", 16'h0, irq_allow);
    @(posedge clk);
    repeat_active <= 1'b0;
  endtask : reg_test

  // External I/O, slow data and global accesses
  task automatic ext_test();
    access(SP_IO, 16'h0010, 1'b1, 16'h6789);
    chk("io lat", 16'h2, lat);
    access(SP_IO, 16'h0010, 1'b0, 16'h0);
    chk("io rd", 16'h6789, rsp_rdata);
    waits <= 4'h3;
    access(SP_DATA, 16'h8000, 1'b0, 16'h0);
    chk("slow lat", 16'h5, lat);
    chk("irq def", 16'h0, irq_seen);
    chk("no br", 16'h0, br_seen);
    access(SP_DATA, 16'hff20, 1'b1, 16'h0bad);
    chk("glob lat", 16'h5, lat);
    chk("br", 16'h1, br_seen);
    chk("br off", 16'h0, bus_request_out);
    waits <= 4'h0;
  endtask : ext_test

  // Hold handover and release
  task automatic hold_test();
    @(posedge clk);
    hold_req_n <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk("oe off", 16'h0, ext_addr_oe);
    chk("ack early", 16'h0, hold_ack_out);
    @(negedge clk);
    chk("ack", 16'h1, hold_ack_out);
    chk("ctrl off", 16'h0, ext_ctrl_oe);
    access(SP_DATA, 16'h0300, 1'b0, 16'h0);
    chk("hold int", 16'h1111, rsp_rdata);
    @(posedge clk);
    hold_req_n <= 1'b1;
    repeat (2) @(negedge clk);
    chk("ack off", 16'h0, hold_ack_out);
    chk("oe on", 16'h1, ext_addr_oe);
    access(SP_IO, 16'h0010, 1'b0, 16'h0);
    chk("after", 16'h6789, rsp_rdata);
  endtask : hold_test

  task automatic conclude();
    $display("Checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  // Reset, then the scenarios
  initial begin
    srst = 1'b1;
    req_valid = 1'b0;
    req_space = SP_DATA;
    req_addr = 16'h0;
    req_write = 1'b0;
    req_wdata = 16'h0;
    map_block_to_data_space = 1'b0;
    map_block_to_program_space = 1'b0;
    repeat_active = 1'b0;
    irq_pending = 1'b1;
    serial_rx_in = 16'h5a3c;
    hold_req_n = 1'b1;
    waits = 4'h0;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk("rst map", 16'h0, block_in_program);
    ram_test();
    reg_test();
    ext_test();
    hold_test();
    conclude();
  end
endmodule : dsp_memory_and_bus_control_tb
